// ==== verilog/clock_fail_monitor.sv ====
// clock fail monitor: supervision register, fail flags and ring oscillator fallback
// assumes an AHB-Lite master and free watched clocks on main_clock_in and crystal_clock_in
`timescale 1ns/100ps
module clock_fail_monitor
  import clock_fail_monitor_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic main_clock_in,
  input wire logic crystal_clock_in,
  output logic use_ring_oscillator,
  output logic main_clock_fail_irq,
  output logic crystal_fail_irq,
  output logic irq
);
  typedef enum logic [0:0] {
    SRC_MAIN = 1'b0,
    SRC_RING = 1'b1
  } source_state_t;

  source_state_t source_state;
  source_state_t next_source_state;
  supervision_ctrl_t ctrl;
  addr_phase_t addr_phase;
  logic accept;
  logic rd_wait;
  logic wr_now;
  logic wr_supervision;
  logic rd_irq_status;
  logic main_pend;
  logic xtal_pend;
  logic main_present;
  logic xtal_present;
  logic main_fail_evt;
  logic xtal_fail_evt;
  logic [15:0] supervision_word;
  logic [EVENT_W-1:0] irq_status;
  logic [EVENT_W-1:0] irq_mask;

  // ****************************************
  // clock watchdogs
  // ****************************************
  clock_presence_detector main_watch (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .enable(ctrl.main_clock_watch_enable),
    .clk_in(main_clock_in),
    .present(main_present),
    .fail(main_fail_evt)
  );

  clock_presence_detector crystal_watch (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .enable(ctrl.crystal_watch_enable),
    .clk_in(crystal_clock_in),
    .present(xtal_present),
    .fail(xtal_fail_evt)
  );

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  assign accept = hsel && htrans[1] && hready && clk_en;
  assign hreadyout = !rd_wait;
  assign hresp = 1'b0;
  assign wr_now = clk_en && addr_phase.valid && addr_phase.write;
  assign wr_supervision = wr_now && offset_is(addr_phase.offset, OFF_SUPERVISION);
  assign rd_irq_status = clk_en && rd_wait && offset_is(addr_phase.offset, OFF_IRQ_STATUS);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_phase <= ADDR_PHASE_RESET;
    end else if (clk_en && hready) begin
      addr_phase.valid <= accept;
      addr_phase.write <= hwrite;
      addr_phase.offset <= haddr[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_wait <= 1'b0;
    end else if (clk_en) begin
      rd_wait <= accept && !hwrite;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hrdata <= 32'h0;
    end else if (clk_en && rd_wait) begin
      if (offset_is(addr_phase.offset, OFF_SUPERVISION)) begin
        hrdata <= {16'h0, supervision_word};
      end else if (offset_is(addr_phase.offset, OFF_IRQ_STATUS)) begin
        hrdata <= {30'h0, irq_status};
      end else if (offset_is(addr_phase.offset, OFF_IRQ_MASK)) begin
        hrdata <= {30'h0, irq_mask};
      end else begin
        hrdata <= 32'h0;
      end
    end
  end

  // ****************************************
  // supervision word
  // ****************************************
  always_comb begin
    supervision_word = 16'h0;
    supervision_word[BIT_RECOVERY_DIS] = ctrl.main_clock_recovery_disable;
    supervision_word[BIT_MAIN_WATCH] = ctrl.main_clock_watch_enable;
    supervision_word[BIT_MAIN_IE] = ctrl.main_clock_fail_irq_enable;
    supervision_word[BIT_MAIN_PEND] = main_pend;
    supervision_word[BIT_MAIN_PRESENT] = main_present;
    supervision_word[BIT_XTAL_WATCH] = ctrl.crystal_watch_enable;
    supervision_word[BIT_XTAL_IE] = ctrl.crystal_fail_irq_enable;
    supervision_word[BIT_XTAL_PEND] = xtal_pend;
    supervision_word[BIT_XTAL_RUN] = xtal_present;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
    end else if (wr_supervision) begin
      ctrl.main_clock_recovery_disable <= hwdata[BIT_RECOVERY_DIS];
      ctrl.main_clock_watch_enable <= hwdata[BIT_MAIN_WATCH];
      ctrl.main_clock_fail_irq_enable <= hwdata[BIT_MAIN_IE];
      ctrl.crystal_watch_enable <= hwdata[BIT_XTAL_WATCH];
      ctrl.crystal_fail_irq_enable <= hwdata[BIT_XTAL_IE];
    end
  end

  // ****************************************
  // fail pending flags, set wins over clear
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      main_pend <= MAIN_PEND_RESET;
    end else if (clk_en) begin
      if (main_fail_evt) begin
        main_pend <= 1'b1;
      end else if (wr_supervision && hwdata[BIT_MAIN_PEND]) begin
        main_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      xtal_pend <= XTAL_PEND_RESET;
    end else if (clk_en) begin
      if (xtal_fail_evt) begin
        xtal_pend <= 1'b1;
      end else if (wr_supervision && hwdata[BIT_XTAL_PEND]) begin
        xtal_pend <= 1'b0;
      end
    end
  end

  assign main_clock_fail_irq = main_pend && ctrl.main_clock_fail_irq_enable;
  assign crystal_fail_irq = xtal_pend && ctrl.crystal_fail_irq_enable;

  // ****************************************
  // event status and combined interrupt
  // ****************************************
  event_irq_status events (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .set({xtal_fail_evt, main_fail_evt}),
    .read_clear(rd_irq_status),
    .mask_write(wr_now && offset_is(addr_phase.offset, OFF_IRQ_MASK)),
    .mask_wdata(hwdata[EVENT_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // ****************************************
  // system clock fallback
  // ****************************************
  always_comb begin
    next_source_state = source_state;
    unique case (source_state)
      SRC_MAIN: begin
        if (main_fail_evt && !ctrl.main_clock_recovery_disable) begin
          next_source_state = SRC_RING;
        end
      end
      SRC_RING: begin
        next_source_state = SRC_RING;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      source_state <= SRC_MAIN;
    end else if (clk_en) begin
      source_state <= next_source_state;
    end
  end

  assign use_ring_oscillator = (source_state == SRC_RING);

  // ****************************************
  // assertions
  // ****************************************
  sequence s_main_fail_recover;
    clk_en && main_fail_evt && !ctrl.main_clock_recovery_disable;
  endsequence

  sequence s_read_accept;
    accept && !hwrite;
  endsequence

  sequence s_read_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  property p_no_recovery;
    @(posedge mclk) disable iff (!rst_n)
      (source_state == SRC_MAIN && ctrl.main_clock_recovery_disable) |=> !use_ring_oscillator;
  endproperty
  a_no_recovery: assert property (p_no_recovery) else $error("fallback taken while recovery disabled");

  property p_main_watch_off;
    @(posedge mclk) disable iff (!rst_n)
      !ctrl.main_clock_watch_enable |-> !main_fail_evt;
  endproperty
  a_main_watch_off: assert property (p_main_watch_off) else $error("main fail seen with watch off");

  property p_main_irq_follow;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && main_fail_evt) ##1 ctrl.main_clock_fail_irq_enable |-> main_clock_fail_irq;
  endproperty
  a_main_irq_follow: assert property (p_main_irq_follow) else $error("main fail request missing");

  property p_main_pend_set;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && main_fail_evt) |=> main_pend && irq_status[EVT_MAIN];
  endproperty
  a_main_pend_set: assert property (p_main_pend_set) else $error("main pending not set");

  property p_main_pend_clear;
    @(posedge mclk) disable iff (!rst_n)
      (wr_supervision && hwdata[BIT_MAIN_PEND] && !main_fail_evt) |=> !main_pend;
  endproperty
  a_main_pend_clear: assert property (p_main_pend_clear) else $error("main pending not cleared");

  property p_main_present_drop;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && main_fail_evt) |=> !main_present ##0 !supervision_word[BIT_MAIN_PRESENT];
  endproperty
  a_main_present_drop: assert property (p_main_present_drop) else $error("main present stays high");

  property p_xtal_watch_off;
    @(posedge mclk) disable iff (!rst_n)
      !ctrl.crystal_watch_enable |-> !xtal_fail_evt;
  endproperty
  a_xtal_watch_off: assert property (p_xtal_watch_off) else $error("crystal fail seen with watch off");

  property p_xtal_irq_block;
    @(posedge mclk) disable iff (!rst_n)
      !ctrl.crystal_fail_irq_enable |-> !crystal_fail_irq;
  endproperty
  a_xtal_irq_block: assert property (p_xtal_irq_block) else $error("crystal request while disabled");

  property p_xtal_pend;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && xtal_fail_evt) |=> xtal_pend ##1 (xtal_pend || $past(wr_supervision && hwdata[BIT_XTAL_PEND]));
  endproperty
  a_xtal_pend: assert property (p_xtal_pend) else $error("crystal pending lost");

  property p_xtal_clear;
    @(posedge mclk) disable iff (!rst_n)
      (wr_supervision && hwdata[BIT_XTAL_PEND] && !xtal_fail_evt) |=> !xtal_pend;
  endproperty
  a_xtal_clear: assert property (p_xtal_clear) else $error("crystal pending not cleared");

  property p_xtal_run_drop;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && xtal_fail_evt) |=> !xtal_present ##0 !supervision_word[BIT_XTAL_RUN];
  endproperty
  a_xtal_run_drop: assert property (p_xtal_run_drop) else $error("crystal running stays high");

  property p_xtal_readback;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && rd_wait && offset_is(addr_phase.offset, OFF_SUPERVISION))
        |=> hrdata[BIT_XTAL_RUN] == $past(xtal_present);
  endproperty
  a_xtal_readback: assert property (p_xtal_readback) else $error("crystal running misread");

  property p_recover_ring;
    @(posedge mclk) disable iff (!rst_n)
      s_main_fail_recover |=> use_ring_oscillator [*3];
  endproperty
  a_recover_ring: assert property (p_recover_ring) else $error("ring fallback not taken");

  property p_irq_pair;
    @(posedge mclk) disable iff (!rst_n)
      $rose(crystal_fail_irq) |-> xtal_pend && ctrl.crystal_fail_irq_enable;
  endproperty
  a_irq_pair: assert property (p_irq_pair) else $error("crystal request without cause");

  property p_read_timing;
    @(posedge mclk) disable iff (!rst_n)
      s_read_accept |=> s_read_answer;
  endproperty
  a_read_timing: assert property (p_read_timing) else $error("read answer timing wrong");

  property p_okay;
    @(posedge mclk) disable iff (!rst_n)
      hsel |-> !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("error response given");
endmodule

// ==== verilog/clock_fail_monitor_pkg.sv ====
// constants, field layout and carrier types of the clock fail monitor
// assumes a 100 MHz mclk and a 32-bit AHB-Lite register bus
package clock_fail_monitor_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLOCK_LOSS_TIME_NS = 1000;
  localparam int CLOCK_LOSS_CYCLES = (CLOCK_LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOSS_CNT_W = 8;
  localparam logic [LOSS_CNT_W-1:0] LOSS_LIMIT = LOSS_CNT_W'(CLOCK_LOSS_CYCLES);
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFF_SUPERVISION = 8'h48;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h4c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h50;
  // ****************************************
  // field positions of the supervision word
  // ****************************************
  localparam int BIT_RECOVERY_DIS = 15;
  localparam int BIT_MAIN_WATCH = 7;
  localparam int BIT_MAIN_IE = 6;
  localparam int BIT_MAIN_PEND = 5;
  localparam int BIT_MAIN_PRESENT = 4;
  localparam int BIT_XTAL_WATCH = 3;
  localparam int BIT_XTAL_IE = 2;
  localparam int BIT_XTAL_PEND = 1;
  localparam int BIT_XTAL_RUN = 0;
  // ****************************************
  // event bits of the interrupt status and mask
  // ****************************************
  localparam int EVENT_W = 2;
  localparam int EVT_MAIN = 0;
  localparam int EVT_XTAL = 1;
  // ****************************************
  // carriers and reset values
  // ****************************************
  typedef struct packed {
    logic main_clock_recovery_disable;
    logic main_clock_watch_enable;
    logic main_clock_fail_irq_enable;
    logic crystal_watch_enable;
    logic crystal_fail_irq_enable;
  } supervision_ctrl_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] offset;
  } addr_phase_t;
  localparam supervision_ctrl_t CTRL_RESET = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  localparam addr_phase_t ADDR_PHASE_RESET = '{1'b0, 1'b0, 8'h00};
  localparam logic MAIN_PEND_RESET = 1'b0;
  localparam logic XTAL_PEND_RESET = 1'b1;
  localparam logic PRESENT_RESET = 1'b1;
  localparam logic [EVENT_W-1:0] IRQ_STATUS_RESET = 2'h0;
  localparam logic [EVENT_W-1:0] IRQ_MASK_RESET = 2'h0;

  function automatic logic offset_is(input logic [7:0] offset, input logic [7:0] target);
    offset_is = (offset == target);
  endfunction
endpackage

// ==== verilog/clock_presence_detector.sv ====
// edge watchdog for one supervised clock sampled on mclk
// assumes the watched clock runs well below half the mclk rate
`timescale 1ns/100ps
module clock_presence_detector
  import clock_fail_monitor_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic enable,
  input wire logic clk_in,
  output logic present,
  output logic fail
);
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic settled;
  logic edge_seen;
  logic loss;
  logic [LOSS_CNT_W-1:0] quiet_cnt;

  // ****************************************
  // three stage synchroniser
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
      settled <= 1'b0;
    end else if (clk_en) begin
      sync_a <= clk_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
      if (edge_seen) begin
        settled <= sync_c;
      end
    end
  end

  assign edge_seen = (sync_b == sync_c) && (sync_c != settled);
  assign loss = enable && !edge_seen && (quiet_cnt == LOSS_LIMIT - 1'b1);
  assign fail = loss && present;

  // ****************************************
  // quiet counter and presence
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      quiet_cnt <= '0;
    end else if (clk_en) begin
      if (!enable || edge_seen) begin
        quiet_cnt <= '0;
      end else if (quiet_cnt != LOSS_LIMIT) begin
        quiet_cnt <= quiet_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      present <= PRESENT_RESET;
    end else if (clk_en) begin
      if (enable && edge_seen) begin
        present <= 1'b1;
      end else if (loss) begin
        present <= 1'b0;
      end
    end
  end
endmodule

// ==== verilog/event_irq_status.sv ====
// sticky event status cleared by read, with mask and one level interrupt
// assumes set from the clock watchdogs and read_clear from the bus slave are single mclk pulses
`timescale 1ns/100ps
module event_irq_status
  import clock_fail_monitor_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [EVENT_W-1:0] set,
  input wire logic read_clear,
  input wire logic mask_write,
  input wire logic [EVENT_W-1:0] mask_wdata,
  output logic [EVENT_W-1:0] status,
  output logic [EVENT_W-1:0] mask,
  output logic irq
);
  // ****************************************
  // status and mask
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status <= IRQ_STATUS_RESET;
    end else if (clk_en) begin
      status <= (read_clear ? '0 : status) | set;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mask <= IRQ_MASK_RESET;
    end else if (clk_en && mask_write) begin
      mask <= mask_wdata;
    end
  end

  assign irq = |(status & mask);
endmodule

// ==== tb/clock_fail_monitor_bench.sv ====
// self-checking bench of the clock fail monitor over its AHB-Lite port
// assumes the design files under verilog/ are compiled first
`timescale 1ns/100ps
module clock_fail_monitor_bench;
  import clock_fail_monitor_pkg::*;
  // ****************************************
  // signals and clocks
  // ****************************************
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic main_clock_in = 1'b0;
  logic crystal_clock_in = 1'b0;
  logic hready, hreadyout, hresp, use_ring_oscillator, main_clock_fail_irq, crystal_fail_irq, irq;
  logic [31:0] hrdata;
  logic main_run = 1'b1;
  logic xtal_run = 1'b1;
  logic [1:0] div = 2'h0;
  logic [31:0] rd;
  int mismatches = 0;
  int tests_run = 0;
  assign hready = hreadyout;
  clock_fail_monitor clock_fail_monitor_inst (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .main_clock_in(main_clock_in),
    .crystal_clock_in(crystal_clock_in), .use_ring_oscillator(use_ring_oscillator),
    .main_clock_fail_irq(main_clock_fail_irq), .crystal_fail_irq(crystal_fail_irq), .irq(irq));
  initial begin
    forever #5 mclk = ~mclk;
  end
  // watched clocks of 60 ns period, held still when stopped
  always @(posedge mclk) begin
    div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
    if (div == 2'h2) begin
      if (main_run) main_clock_in <= ~main_clock_in;
      if (xtal_run) crystal_clock_in <= ~crystal_clock_in;
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask
  task automatic do_reset();
    @(posedge mclk);
    rst_n <= 1'b0;
    main_run <= 1'b1;
    xtal_run <= 1'b1;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
  endtask
  task automatic stop_main();
    @(posedge mclk);
    main_run <= 1'b0;
    repeat (130) @(posedge mclk);
    @(negedge mclk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_values();
    do_reset();
    rchk("supervision", OFF_SUPERVISION, 32'h0093);
    rchk("irq_status", OFF_IRQ_STATUS, 32'h0);
    rchk("irq_mask", OFF_IRQ_MASK, 32'h0);
    bus(1'b1, 8'h60, 32'hffff_ffff);
    rchk("unmapped", 8'h60, 32'h0);
    chk("ring", 32'h0, {31'h0, use_ring_oscillator});
  endtask
  task automatic t_main_fail();
    do_reset();
    bus(1'b1, OFF_SUPERVISION, 32'h0000_00c0);
    bus(1'b1, OFF_IRQ_MASK, 32'h0000_0001);
    stop_main();
    chk("ring", 32'h1, {31'h0, use_ring_oscillator});
    chk("main_irq", 32'h1, {31'h0, main_clock_fail_irq});
    chk("irq", 32'h1, {31'h0, irq});
    rchk("supervision", OFF_SUPERVISION, 32'h00e3);
    rchk("irq_status", OFF_IRQ_STATUS, 32'h1);
    @(negedge mclk);
    chk("irq", 32'h0, {31'h0, irq});
    bus(1'b1, OFF_SUPERVISION, 32'h0000_00e0);
    rchk("supervision", OFF_SUPERVISION, 32'h00c3);
    chk("main_irq", 32'h0, {31'h0, main_clock_fail_irq});
    @(posedge mclk);
    main_run <= 1'b1;
    repeat (20) @(posedge mclk);
    rchk("supervision", OFF_SUPERVISION, 32'h00d3);
  endtask
  task automatic t_recovery_off();
    do_reset();
    bus(1'b1, OFF_SUPERVISION, 32'h0000_8080);
    stop_main();
    chk("ring", 32'h0, {31'h0, use_ring_oscillator});
    chk("main_irq", 32'h0, {31'h0, main_clock_fail_irq});
    rchk("supervision", OFF_SUPERVISION, 32'h80a3);
  endtask
  task automatic t_watch_off();
    do_reset();
    bus(1'b1, OFF_SUPERVISION, 32'h0000_0040);
    stop_main();
    chk("ring", 32'h0, {31'h0, use_ring_oscillator});
    chk("main_irq", 32'h0, {31'h0, main_clock_fail_irq});
    rchk("supervision", OFF_SUPERVISION, 32'h0053);
  endtask
  task automatic t_crystal();
    do_reset();
    bus(1'b1, OFF_SUPERVISION, 32'h0000_008e);
    @(negedge mclk);
    chk("xtal_irq", 32'h0, {31'h0, crystal_fail_irq});
    rchk("supervision", OFF_SUPERVISION, 32'h009d);
    bus(1'b1, OFF_IRQ_MASK, 32'h0000_0002);
    @(posedge mclk);
    xtal_run <= 1'b0;
    repeat (130) @(posedge mclk);
    @(negedge mclk);
    chk("xtal_irq", 32'h1, {31'h0, crystal_fail_irq});
    chk("irq", 32'h1, {31'h0, irq});
    chk("ring", 32'h0, {31'h0, use_ring_oscillator});
    rchk("supervision", OFF_SUPERVISION, 32'h009e);
    rchk("irq_status", OFF_IRQ_STATUS, 32'h2);
    bus(1'b1, OFF_SUPERVISION, 32'h0000_0088);
    @(negedge mclk);
    chk("xtal_irq", 32'h0, {31'h0, crystal_fail_irq});
    chk("irq", 32'h0, {31'h0, irq});
  endtask
  task automatic t_freeze();
    do_reset();
    @(posedge mclk);
    clk_en <= 1'b0;
    main_run <= 1'b0;
    repeat (130) @(posedge mclk);
    chk("ring_frozen", 32'h0, {31'h0, use_ring_oscillator});
    clk_en <= 1'b1;
    repeat (130) @(posedge mclk);
    chk("ring", 32'h1, {31'h0, use_ring_oscillator});
  endtask
  // ****************************************
  // run control
  // ****************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    end_sim();
  end
  initial begin
    t_reset_values();
    t_main_fail();
    t_recovery_off();
    t_watch_off();
    t_crystal();
    t_freeze();
    end_sim();
  end
endmodule
